// file: rtl/ufb_pkg.sv
// Package for the serial frame and baud configuration block
package ufb_pkg;
   // Register offsets
   localparam logic [3:0] OFS_CTRL_A = 4'h0;
   localparam logic [3:0] OFS_CTRL_B = 4'h1;
   localparam logic [3:0] OFS_CTRL_C = 4'h2;
   localparam logic [3:0] OFS_BAUD_LO = 4'h3;
   localparam logic [3:0] OFS_BAUD_HI = 4'h4;
   localparam logic [3:0] OFS_TX_DATA = 4'h5;
   localparam logic [3:0] OFS_RX_DATA = 4'h6;
   localparam logic [3:0] OFS_STATUS = 4'h7;
   // Field positions
   localparam int A_DOUBLE = 1;
   localparam int B_RX_EN = 4;
   localparam int B_TX_EN = 3;
   localparam int B_SIZE_TOP = 2;
   localparam int B_RX_NINTH = 1;
   localparam int B_TX_NINTH = 0;
   localparam int C_MODE_HI = 7;
   localparam int C_MODE_LO = 6;
   localparam int C_PAR_HI = 5;
   localparam int C_PAR_LO = 4;
   localparam int C_STOP = 3;
   localparam int C_SIZE_HI = 2;
   localparam int C_SIZE_LO = 1;
   localparam int C_POL = 0;
   localparam int S_RX_VALID = 0;
   localparam int S_TX_READY = 1;
   localparam int S_PAR_ERR = 2;
   localparam int S_FRAME_ERR = 3;
   // Reset values and the high divisor mask
   localparam logic [7:0] CTRL_C_RST = 8'h06;
   localparam logic [7:0] ZERO8 = 8'h00;
   localparam logic [3:0] HI_MASK = 4'hf;
   // Codes
   localparam logic [1:0] MODE_ASYNC = 2'b00;
   localparam logic [1:0] MODE_SYNC = 2'b01;
   localparam logic [1:0] PAR_EVEN = 2'b10;
   localparam logic [1:0] PAR_ODD = 2'b11;
   localparam logic [3:0] OVS_NORMAL = 4'hf;
   localparam logic [3:0] OVS_DOUBLE = 4'h7;
   localparam logic [3:0] OVS_MID_N = 4'h7;
   localparam logic [3:0] OVS_MID_D = 4'h3;
   localparam logic [3:0] LEN_BASE = 4'h5;
   localparam logic [3:0] LEN_NINE = 4'h9;
   localparam logic [2:0] SIZE_NINE = 3'b111;
   // Frame character with its ninth bit
   typedef struct packed {
      logic ninth;
      logic [7:0] low;
   } ufb_char_t;
   // Frame format carried to the shifters
   typedef struct packed {
      logic [1:0] mode;
      logic [1:0] parity;
      logic two_stop;
      logic [3:0] data_len;
      logic polarity;
      logic double_speed;
   } ufb_fmt_t;
   // Data bits for a size code
   function automatic logic [3:0] ufb_len(input logic [2:0] code);
      ufb_len = (code == SIZE_NINE) ? LEN_NINE : LEN_BASE + {2'b00, code[1:0]};
   endfunction
   // Parity bit over the active data bits
   function automatic logic ufb_par(input ufb_char_t c, input logic [3:0] len, input logic odd);
      logic p;
      p = odd;
      for (int i = 0; i < 9; i++)
         if (i < int'(len))
            p = p ^ c[i];
      ufb_par = p;
   endfunction
endpackage

// file: rtl/ufb_buf2.sv
// Two-entry valid/ready buffer for received characters
`timescale 1ns/100ps
module ufb_buf2
   import ufb_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire ufb_char_t in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output ufb_char_t out_data
);
   logic [1:0] cnt_q, cnt_d;
   ufb_char_t mem_q [2];
   ufb_char_t mem_d [2];
   logic rd_q, rd_d;
   logic wr_q, wr_d;
   logic push, pop;

   assign in_ready = (cnt_q != 2'd2);
   assign out_valid = (cnt_q != 2'd0);
   assign out_data = mem_q[rd_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Pointers and count
   always_comb
   begin
      mem_d = mem_q;
      rd_d = rd_q;
      wr_d = wr_q;
      cnt_d = cnt_q;
      if (push)
      begin
         mem_d[wr_q] = in_data;
         wr_d = ~wr_q;
      end
      if (pop)
         rd_d = ~rd_q;
      cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cnt_q <= 2'd0;
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         mem_q[0] <= '0;
         mem_q[1] <= '0;
      end
      else
      begin
         cnt_q <= cnt_d;
         rd_q <= rd_d;
         wr_q <= wr_d;
         mem_q <= mem_d;
      end
   end

   AST_NO_OVERFLOW: assert property (@(posedge sys_clk) disable iff (!reset_n) cnt_q <= 2'd2)
      else $error("buffer count beyond two");
endmodule

// file: rtl/ufb_top.sv
// Serial transceiver with frame format and baud divisor configuration
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/100ps
module ufb_top
   import ufb_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Serial pins
   output logic transmit_pin,
   input wire logic receive_pin,
   output logic sync_clock_pin,
   output logic sync_clock_oe
);
   typedef enum {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} ufb_state_t;

   // Configuration registers
   logic [7:0] ctrl_a_q, ctrl_a_d, ctrl_b_q, ctrl_b_d, ctrl_c_q, ctrl_c_d;
   logic [11:0] baud_q, baud_d;
   logic [7:0] rdata_q, rdata_d;
   ufb_char_t tx_hold_q, tx_hold_d;
   logic tx_full_q, tx_full_d;
   ufb_fmt_t fmt;
   // Prescaler and bit tick
   logic [11:0] pre_q, pre_d;
   logic [3:0] ovs_q, ovs_d;
   logic os_tick, bit_tick, sclk_q, sclk_d;
   // Transmitter
   ufb_state_t tst_q, tst_d;
   ufb_char_t tsh_q, tsh_d;
   logic [3:0] tcnt_q, tcnt_d;
   logic txo_q, txo_d;
   // Receiver
   ufb_state_t rst_q, rst_d;
   ufb_char_t rsh_q, rsh_d;
   logic [3:0] rcnt_q, rcnt_d, rovs_q, rovs_d;
   logic rpar_q, rpar_d, rx_push, perr_q, perr_d, ferr_q, ferr_d;
   logic rx_prev_q, rx_samp;
   // Buffer wires
   logic buf_in_ready, buf_out_valid, buf_pop;
   ufb_char_t buf_out;

   // Frame format decode
   always_comb
   begin
      fmt.mode = ctrl_c_q[C_MODE_HI:C_MODE_LO];
      fmt.parity = ctrl_c_q[C_PAR_HI:C_PAR_LO];
      fmt.two_stop = ctrl_c_q[C_STOP];
      fmt.data_len = ufb_len({ctrl_b_q[B_SIZE_TOP], ctrl_c_q[C_SIZE_HI:C_SIZE_LO]});
      fmt.polarity = ctrl_c_q[C_POL];
      fmt.double_speed = ctrl_a_q[A_DOUBLE] && (fmt.mode == MODE_ASYNC);
   end

   wire logic is_sync = (fmt.mode == MODE_SYNC);
   assign buf_pop = reg_rd && (reg_addr == OFS_RX_DATA);

   // Register writes and read data
   always_comb
   begin
      ctrl_a_d = ctrl_a_q;
      ctrl_b_d = ctrl_b_q;
      ctrl_c_d = ctrl_c_q;
      baud_d = baud_q;
      tx_hold_d = tx_hold_q;
      tx_full_d = tx_full_q;
      rdata_d = ZERO8;
      if (tst_q == ST_IDLE && tx_full_q && ctrl_b_q[B_TX_EN])
         tx_full_d = 1'b0;
      if (reg_wr)
      begin
         unique case (reg_addr)
            OFS_CTRL_A: ctrl_a_d = reg_wdata;
            OFS_CTRL_B: ctrl_b_d = reg_wdata;
            OFS_CTRL_C: ctrl_c_d = reg_wdata;
            OFS_BAUD_LO: baud_d[7:0] = reg_wdata;
            OFS_BAUD_HI: baud_d[11:8] = reg_wdata[3:0] & HI_MASK;
            OFS_TX_DATA:
            begin
               // Ninth bit taken from control B at write time
               tx_hold_d = '{ninth: ctrl_b_q[B_TX_NINTH], low: reg_wdata};
               tx_full_d = 1'b1;
            end
            default: ;
         endcase
      end
      if (reg_rd)
      begin
         unique case (reg_addr)
            OFS_CTRL_A: rdata_d = ctrl_a_q;
            OFS_CTRL_B: rdata_d = {ctrl_b_q[7:2], buf_out.ninth, ctrl_b_q[0]};
            OFS_CTRL_C: rdata_d = ctrl_c_q;
            OFS_BAUD_LO: rdata_d = baud_q[7:0];
            OFS_BAUD_HI: rdata_d = {4'h0, baud_q[11:8]};
            OFS_RX_DATA: rdata_d = buf_out.low;
            OFS_STATUS:
            begin
               rdata_d[S_RX_VALID] = buf_out_valid;
               rdata_d[S_TX_READY] = ~tx_full_q;
               rdata_d[S_PAR_ERR] = perr_q;
               rdata_d[S_FRAME_ERR] = ferr_q;
            end
            default: rdata_d = ZERO8;
         endcase
      end
   end

   // Prescaler: down-counter reloaded on a low divisor write
   always_comb
   begin
      pre_d = pre_q;
      ovs_d = ovs_q;
      sclk_d = sclk_q;
      os_tick = (pre_q == 12'h000);
      bit_tick = 1'b0;
      if (reg_wr && reg_addr == OFS_BAUD_LO)
      begin
         pre_d = {baud_q[11:8], reg_wdata};
         ovs_d = 4'h0;
      end
      else if (os_tick)
      begin
         pre_d = baud_q;
         if (ovs_q == (fmt.double_speed ? OVS_DOUBLE : OVS_NORMAL))
         begin
            ovs_d = 4'h0;
            bit_tick = 1'b1;
         end
         else
            ovs_d = ovs_q + 4'h1;
         if (ovs_q == OVS_MID_N)
            sclk_d = 1'b1;
      end
      else
         pre_d = pre_q - 12'h001;
      if (bit_tick)
         sclk_d = 1'b0;
   end

   // Transmitter sequence
   always_comb
   begin
      tst_d = tst_q;
      tsh_d = tsh_q;
      tcnt_d = tcnt_q;
      txo_d = txo_q;
      unique case (tst_q)
         ST_IDLE:
         begin
            txo_d = 1'b1;
            if (tx_full_q && ctrl_b_q[B_TX_EN])
            begin
               tsh_d = tx_hold_q;
               tst_d = ST_START;
            end
         end
         ST_START: if (bit_tick)
         begin
            txo_d = 1'b0;
            tcnt_d = 4'h0;
            tst_d = ST_DATA;
         end
         ST_DATA: if (bit_tick)
         begin
            txo_d = tsh_q[tcnt_q];
            tcnt_d = tcnt_q + 4'h1;
            if (tcnt_q + 4'h1 == fmt.data_len)
               tst_d = (fmt.parity[1]) ? ST_PAR : ST_STOP;
         end
         ST_PAR: if (bit_tick)
         begin
            txo_d = ufb_par(tsh_q, fmt.data_len, fmt.parity == PAR_ODD);
            tst_d = ST_STOP;
            tcnt_d = 4'h0;
         end
         ST_STOP: if (bit_tick)
         begin
            txo_d = 1'b1;
            if (tcnt_q[0] || !fmt.two_stop || tcnt_q == fmt.data_len)
               tst_d = ST_IDLE;
            tcnt_d = (tcnt_q == fmt.data_len) ? 4'h1 : tcnt_q + 4'h1;
         end
      endcase
      if (tst_q == ST_DATA && bit_tick && tcnt_q + 4'h1 == fmt.data_len && !fmt.parity[1])
         tcnt_d = 4'h0;
   end

   // Receive sample edge; in sync mode the pin edge opposite the launch edge falls mid bit for either polarity
   assign rx_samp = is_sync ? (os_tick && ovs_q == OVS_MID_N)
                            : (os_tick && rovs_q == (fmt.double_speed ? OVS_MID_D : OVS_MID_N));

   // Receiver sequence; stop select is never consulted
   always_comb
   begin
      rst_d = rst_q;
      rsh_d = rsh_q;
      rcnt_d = rcnt_q;
      rovs_d = rovs_q;
      rpar_d = rpar_q;
      perr_d = perr_q;
      ferr_d = ferr_q;
      rx_push = 1'b0;
      // Own phase counter restarts at each start edge, so async sampling lands mid bit
      if (rst_q != ST_IDLE && os_tick)
         rovs_d = (rovs_q == (fmt.double_speed ? OVS_DOUBLE : OVS_NORMAL)) ? 4'h0 : rovs_q + 4'h1;
      if (buf_pop)
      begin
         perr_d = 1'b0;
         ferr_d = 1'b0;
      end
      unique case (rst_q)
         ST_IDLE:
            if (ctrl_b_q[B_RX_EN] && rx_prev_q && !receive_pin)
            begin
               rst_d = ST_START;
               rsh_d = '0;
               rovs_d = 4'h0;
            end
         ST_START: if (rx_samp)
         begin
            rst_d = receive_pin ? ST_IDLE : ST_DATA;
            rcnt_d = 4'h0;
         end
         ST_DATA: if (rx_samp)
         begin
            rsh_d[rcnt_q] = receive_pin;
            rcnt_d = rcnt_q + 4'h1;
            if (rcnt_q + 4'h1 == fmt.data_len)
               rst_d = fmt.parity[1] ? ST_PAR : ST_STOP;
         end
         ST_PAR: if (rx_samp)
         begin
            rpar_d = receive_pin ^ ufb_par(rsh_q, fmt.data_len, fmt.parity == PAR_ODD);
            rst_d = ST_STOP;
         end
         ST_STOP: if (rx_samp)
         begin
            // Only the first stop bit is checked
            rx_push = buf_in_ready;
            if (buf_in_ready)
            begin
               perr_d = rpar_q && fmt.parity[1]; // Set wins over read clear
               ferr_d = ~receive_pin;
            end
            rpar_d = 1'b0;
            rst_d = ST_IDLE;
         end
      endcase
   end

   // Data path, receive pin sample and all state except the output pins
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctrl_a_q <= ZERO8;
         ctrl_b_q <= ZERO8;
         ctrl_c_q <= CTRL_C_RST;
         baud_q <= 12'h000;
         rdata_q <= ZERO8;
         tx_hold_q <= '0;
         tx_full_q <= 1'b0;
         pre_q <= 12'h000;
         ovs_q <= 4'h0;
         sclk_q <= 1'b0;
         tst_q <= ST_IDLE;
         tsh_q <= '0;
         tcnt_q <= 4'h0;
         txo_q <= 1'b1;
         rst_q <= ST_IDLE;
         rsh_q <= '0;
         rcnt_q <= 4'h0;
         rovs_q <= 4'h0;
         rpar_q <= 1'b0;
         perr_q <= 1'b0;
         ferr_q <= 1'b0;
         rx_prev_q <= 1'b1;
      end
      else
      begin
         ctrl_a_q <= ctrl_a_d;
         ctrl_b_q <= ctrl_b_d;
         ctrl_c_q <= ctrl_c_d;
         baud_q <= baud_d;
         rdata_q <= rdata_d;
         tx_hold_q <= tx_hold_d;
         tx_full_q <= tx_full_d;
         pre_q <= pre_d;
         ovs_q <= ovs_d;
         sclk_q <= sclk_d;
         tst_q <= tst_d;
         tsh_q <= tsh_d;
         tcnt_q <= tcnt_d;
         txo_q <= txo_d;
         rst_q <= rst_d;
         rsh_q <= rsh_d;
         rcnt_q <= rcnt_d;
         rovs_q <= rovs_d;
         rpar_q <= rpar_d;
         perr_q <= perr_d;
         ferr_q <= ferr_d;
         rx_prev_q <= receive_pin;
      end
   end

   // Outputs; sync clock inverted by polarity so data moves on chosen edge
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         transmit_pin <= 1'b1;
         sync_clock_pin <= 1'b0;
         sync_clock_oe <= 1'b0;
      end
      else
      begin
         transmit_pin <= txo_d;
         sync_clock_pin <= sclk_d ^ ~ctrl_c_q[C_POL];
         sync_clock_oe <= is_sync;
      end
   end
   assign reg_rdata = rdata_q;

   // Two-entry character buffer; a frame that arrives while it is full is dropped
   ufb_buf2 u_buf (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .in_valid(rx_push),
      .in_ready(buf_in_ready),
      .in_data(rsh_q),
      .out_valid(buf_out_valid),
      .out_ready(buf_pop),
      .out_data(buf_out)
   );

   AST_HI_READ_ZERO: assert property (@(posedge sys_clk) disable iff (!reset_n)
      reg_rd && reg_addr == OFS_BAUD_HI |=> reg_rdata[7:4] == 4'h0) else $error("high divisor reserved bits set");
   AST_RELOAD: assert property (@(posedge sys_clk) disable iff (!reset_n)
      reg_wr && reg_addr == OFS_BAUD_LO |=> pre_q == {baud_q[11:8], $past(reg_wdata)}) else $error("no reload");
   AST_DIV_LO: assert property (@(posedge sys_clk) disable iff (!reset_n)
      reg_wr && reg_addr == OFS_BAUD_LO |=> baud_q[7:0] == $past(reg_wdata)) else $error("low divisor lost");
   AST_COUNT_DOWN: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !reg_wr && pre_q != 12'h000 |=> pre_q == $past(pre_q) - 12'h001) else $error("prescaler not counting down");
   AST_START_LOW: assert property (@(posedge sys_clk) disable iff (!reset_n)
      tst_q == ST_START && bit_tick |=> !transmit_pin) else $error("start bit not low");
   AST_IDLE_HIGH: assert property (@(posedge sys_clk) disable iff (!reset_n)
      tst_q == ST_IDLE && $past(tst_q) == ST_IDLE |-> transmit_pin) else $error("idle line not high");
   AST_SIZE: assert property (@(posedge sys_clk) disable iff (!reset_n)
      {ctrl_b_q[B_SIZE_TOP], ctrl_c_q[C_SIZE_HI:C_SIZE_LO]} == 3'b011 |-> fmt.data_len == 4'h8)
      else $error("size code wrong");
   AST_DOUBLE: assert property (@(posedge sys_clk) disable iff (!reset_n)
      bit_tick && fmt.double_speed |-> ovs_q == OVS_DOUBLE) else $error("double speed factor wrong");
   AST_STOP_END: assert property (@(posedge sys_clk) disable iff (!reset_n)
      tst_q == ST_STOP && bit_tick && !fmt.two_stop |=> tst_q == ST_IDLE) else $error("extra stop bit");
   AST_OE_SYNC: assert property (@(posedge sys_clk) disable iff (!reset_n)
      ##1 sync_clock_oe == ($past(ctrl_c_q[C_MODE_HI:C_MODE_LO]) == MODE_SYNC)) else $error("sync clock enable wrong");
   COV_TX_FRAME: cover property (@(posedge sys_clk) tst_q == ST_STOP ##1 tst_q == ST_IDLE);
   COV_RX_PUSH: cover property (@(posedge sys_clk) rx_push);
   COV_PAR: cover property (@(posedge sys_clk) tst_q == ST_PAR && bit_tick);
   COV_BUF_FULL: cover property (@(posedge sys_clk) !buf_in_ready);
endmodule

// file: bench/ufb_remote.sv
// Far-side serial transceiver model: frame capture and frame drive
`timescale 1ns/100ps
module ufb_remote (
   // Clock
   input wire logic sys_clk,
   // Line from the block
   input wire logic line_in,
   // Line into the block
   output logic line_out
);
   // Line rests at its idle high level between frames
   initial line_out = 1'b1;

   // Find a start edge, then sample n bits mid-bit; ok stays low on a silent line
   task automatic take(input int per, input int n, output logic [12:0] f, output logic ok);
      f = '1;
      ok = 1'b0;
      for (int w = 0; w < 20000 && !ok; w++)
      begin
         @(posedge sys_clk);
         ok = (line_in === 1'b0);
      end
      repeat (per / 2) @(posedge sys_clk);
      for (int i = 0; i < n; i++)
      begin
         f[i] = line_in;
         repeat (per) @(posedge sys_clk);
      end
   endtask

   // Drive n bits, then one idle cycle so frames never merge
   task automatic give(input int per, input int n, input logic [12:0] f);
      for (int i = 0; i < n; i++)
      begin
         line_out <= f[i];
         repeat (per) @(posedge sys_clk);
      end
      line_out <= 1'b1;
      @(posedge sys_clk);
   endtask
endmodule

// file: bench/testbench.sv
// Self-checking bench for the serial frame and baud configuration block
`timescale 1ns/100ps
module testbench
   import ufb_pkg::*;
;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic transmit_pin;
   logic receive_pin;
   logic sync_clock_pin;
   logic sync_clock_oe;
   int bad_count = 0;
   int comparisons = 0;
   logic [31:0] seed = 32'h0001_18b7;
   logic sync_watch = 1'b0;
   logic pol = 1'b0;
   logic last_tx = 1'b1;
   int per = 16;
   logic [2:0] codes [5] = '{3'b000, 3'b001, 3'b010, 3'b011, 3'b111};

   // 100 MHz clock
   always #5 sys_clk = ~sys_clk;

   ufb_top u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .transmit_pin(transmit_pin),
      .receive_pin(receive_pin), .sync_clock_pin(sync_clock_pin), .sync_clock_oe(sync_clock_oe));
   ufb_remote u_far (.sys_clk(sys_clk), .line_in(transmit_pin), .line_out(receive_pin));

   task automatic check(input logic [12:0] seen, input logic [12:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return x[0] ? (x >> 1) ^ 32'h8020_0003 : x >> 1;
   endfunction

   // Expected line bits from the start bit on; stops and idle read as ones
   function automatic logic [12:0] frame(input logic [8:0] d, input int len, input logic [1:0] pm);
      logic [12:0] f;
      logic p;
      f = '1;
      f[0] = 1'b0;
      p = pm[0];
      for (int i = 0; i < len; i++)
      begin
         f[i + 1] = d[i];
         p = p ^ d[i];
      end
      if (pm[1])
         f[len + 1] = p;
      return f;
   endfunction

   // Register port: one-cycle strobes, read data in the following cycle only
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic poll(input int b);
      logic [7:0] s;
      for (int n = 0; n < 5000; n++)
      begin
         rd(OFS_STATUS, s);
         if (s[b] === 1'b1)
            return;
      end
      bad_count++;
      tally_and_finish();
   endtask

   // High half before low, since the low write reloads the prescaler
   task automatic cfg(input logic [2:0] code, input logic [1:0] pm, input logic st, input logic [1:0] mode,
      input logic dbl, input logic [11:0] div, input logic ninth);
      wr(OFS_CTRL_A, {6'h00, dbl, 1'b0});
      wr(OFS_CTRL_C, {mode, pm, st, code[1:0], pol});
      wr(OFS_CTRL_B, {5'h03, code[2], 1'b0, ninth});
      wr(OFS_BAUD_HI, {4'h0, div[11:8]});
      wr(OFS_BAUD_LO, div[7:0]);
      per = (int'(div) + 1) * ((dbl && mode == MODE_ASYNC) ? 8 : 16);
   endtask

   task automatic tx_one(input logic [8:0] d, input int len, input logic [1:0] pm, input int st);
      logic [12:0] f;
      logic ok;
      poll(S_TX_READY);
      wr(OFS_TX_DATA, d[7:0]);
      u_far.take(per, 1 + len + pm[1] + st, f, ok);
      if (!ok)
      begin
         bad_count++;
         tally_and_finish();
      end
      check(f, frame(d, len, pm));
   endtask

   // Ninth bit is read ahead of the low byte, which pops the buffer
   task automatic rx_get(input logic [8:0] d, input int len, input logic [1:0] err);
      logic [7:0] s;
      logic [7:0] b;
      logic [7:0] lo;
      rd(OFS_STATUS, s);
      check({s[S_FRAME_ERR], s[S_PAR_ERR], s[S_RX_VALID]}, {err, 1'b1});
      rd(OFS_CTRL_B, b);
      rd(OFS_RX_DATA, lo);
      check({b[B_RX_NINTH], lo}, d & ((9'h001 << len) - 9'h001));
   endtask

   // Data may move only on the launch edge that the polarity picks
   always @(posedge sys_clk)
   begin
      #1;
      if (sync_watch && transmit_pin !== last_tx)
         check(sync_clock_pin, {~pol});
      last_tx = transmit_pin;
   end

   initial
   begin
      logic [7:0] v;
      logic [8:0] d;
      logic [2:0] code;
      logic [1:0] pm;
      int len;
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      rd(OFS_CTRL_C, v);
      check(v, 8'h06);
      wr(4'hf, 8'hff);
      rd(4'hf, v);
      check({transmit_pin, sync_clock_oe, v}, 10'h200);
      $display("Test reset and unmapped index done");
      // Random formats over every data length; receiver gets random stop counts
      for (int i = 0; i < 15; i++)
      begin
         seed = lfsr(seed);
         code = codes[i % 5];
         pm = (seed[1:0] == 2'b01) ? 2'b00 : seed[1:0];
         len = (code == 3'b111) ? 9 : 5 + int'(code[1:0]);
         d = seed[16:8];
         cfg(code, pm, seed[2], MODE_ASYNC, seed[3], {10'h000, seed[5:4]}, d[8]);
         tx_one(d, len, pm, 1 + seed[2]);
         u_far.give(per, 2 + len + pm[1] + seed[6], frame(d, len, pm));
         rx_get(d, len, 2'b00);
      end
      $display("Test random formats done");
      // Slow divisor where the high half counts
      cfg(3'b000, 2'b00, 1'b0, MODE_ASYNC, 1'b1, 12'h100, 1'b0);
      rd(OFS_BAUD_HI, v);
      check(v, 8'h01);
      tx_one(9'h0a5, 5, 2'b00, 1);
      $display("Test wide divisor done");
      // Bad parity, bad stop, then three frames into a two-entry buffer
      cfg(3'b011, 2'b10, 1'b0, MODE_ASYNC, 1'b0, 12'h001, 1'b0);
      u_far.give(per, 11, frame(9'h03c, 8, 2'b10) ^ 13'h0200);
      rx_get(9'h03c, 8, 2'b01);
      u_far.give(per, 11, frame(9'h0c3, 8, 2'b10) ^ 13'h0400);
      rx_get(9'h0c3, 8, 2'b10);
      for (int i = 0; i < 3; i++)
         u_far.give(per, 11, frame(9'(17 * i), 8, 2'b10));
      rx_get(9'h000, 8, 2'b00);
      rx_get(9'h011, 8, 2'b00);
      rd(OFS_STATUS, v);
      check(v[S_RX_VALID], 1'b0);
      $display("Test errors and buffer done");
      // Synchronous mode at both polarities, then the remaining mode codes
      for (int k = 0; k < 2; k++)
      begin
         pol = k[0];
         cfg(3'b011, 2'b00, 1'b1, MODE_SYNC, 1'b0, 12'h000, 1'b0);
         check(sync_clock_oe, 1'b1);
         sync_watch = 1'b1;
         tx_one(9'h05a, 8, 2'b00, 2);
         sync_watch = 1'b0;
      end
      pol = 1'b0;
      for (int k = 2; k < 4; k++)
      begin
         wr(OFS_CTRL_C, {k[1:0], 6'h06});
         rd(OFS_CTRL_C, v);
         check({sync_clock_oe, v}, {1'b0, k[1:0], 6'h06});
      end
      $display("Test sync and mode codes done");
      tally_and_finish();
   end
endmodule
